// [bench/awpc_bench.sv]
// Register-level bench for the wake and power control block
`default_nettype none
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin error_cnt++; \
   $display("mismatch %s exp %0h got %0h", n, x, g); end end
module awpc_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import awpc_pkg::*;
   logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic pready, pslverr, e, irq, system_power_on, power_good, chassis_intrusion_clear;
   logic lreset_n = 1, standby_domain_good = 0, gpio_25_27_reset_n;
   logic mouse_extra_key_select = 1; // Same-clock select, steered by the tests
   logic [4:0] gpio_group_reset_n;
   logic [6:0] ev_req = '0, ev_pin;
   int error_cnt = 0, cmp_count = 0, cyc = 0;
   int ev_bit [4] = '{6, 5, 2, 0}; // Thermal, switch, mouse activity, key sequence
   always #5 clk_sys = ~clk_sys;
   awpc_host_model host_u (.clk_sys, .rst_n, .ev_req, .ev_pin);
   awpc_top #(.cycles_per_ms(4)) dut_u (.clk_sys, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .thermal_shutdown(ev_pin[6]),
      .power_switch_input(ev_pin[5]), .mouse_left_click(ev_pin[3]),
      .mouse_right_click(ev_pin[4]), .mouse_activity(ev_pin[2]), .key_any(ev_pin[1]),
      .key_sequence_match(ev_pin[0]), .lreset_n, .resume_well_reset_n(1'b1),
      .main_supply_good(1'b1), .standby_domain_good, .mouse_right_key_select(1'b0),
      .mouse_extra_key_select, .system_power_on, .power_good,
      .chassis_intrusion_clear, .gpio_group_reset_n, .gpio_25_27_reset_n, .irq);
   // One APB transfer; held until pready is seen at an edge
   task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next call never drives psel twice in one step
      @(posedge clk_sys);
   endtask : xfer
   task wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, {24'h0, d});
   endtask : wr
   task rd(input logic [7:0] idx, input logic [31:0] x, input string n);
      xfer(1'b0, idx, 32'h0);
      `CHK(n, x, q)
   endtask : rd
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt
   // One event pulse on pin b, then time for the filter and status to settle
   task pulse(input int b);
      ev_req[b] <= 1'b1;
      wt(1);
      ev_req <= '0;
      wt(12);
   endtask : pulse
   // Drop standby, bring it back, compare the recovered power state
   task cycle_pwr(input logic x);
      standby_domain_good <= 1'b0;
      wt(8);
      standby_domain_good <= 1'b1;
      wt(8);
      `CHK("power_on", x, system_power_on)
   endtask : cycle_pwr
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // Ceiling well above the roughly 1150 cycles the sequence takes
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end
   initial
   begin
      wt(3);
      rst_n <= 1'b1;
      rd(IDX_OPTION, 32'h0, "option");
      rd(IDX_GPIO_RST, 32'h0, "gpio_src");
      rd(IDX_WAKE_PG, 32'h1c, "wake_pg");
      xfer(1'b0, 8'h04, 32'h0);
      `CHK("unmapped", 1'b1, e)
      wr(IDX_WAKE_PG, 8'h9c);
      wr(IDX_IRQ_MASK, 8'h0e);
      // Each event: irq unless masked, status read once then cleared
      for (int k = 0; k < 4; k++)
      begin
         pulse(ev_bit[k]);
         `CHK("irq", k != 3, irq)
         rd(IDX_STATUS, 32'h8 >> k, "status");
         rd(IDX_STATUS, 32'h0, "status_clr");
         wr(IDX_IRQ_STS, 8'h8 >> k);
         wt(1);
         `CHK("irq_clr", 1'b0, irq)
      end
      // Any-key option with hunting; the wake clears hunting only
      wr(IDX_OPTION, 8'h0c);
      pulse(1);
      rd(IDX_OPTION, 32'h08, "hunt_clr");
      rd(IDX_STATUS, 32'h01, "any_key");
      // Mouse enable without extra key: movement ignored, right click wakes
      mouse_extra_key_select <= 1'b0;
      pulse(2);
      rd(IDX_STATUS, 32'h00, "no_act");
      pulse(4);
      rd(IDX_STATUS, 32'h02, "right_key");
      mouse_extra_key_select <= 1'b1;
      // Blocked groups ignore the LPC reset; GP25-27 follow resume reset
      wr(IDX_GPIO_RST, 8'ha4);
      lreset_n <= 1'b0;
      wt(8);
      `CHK("grp_rst", 5'h14, gpio_group_reset_n)
      `CHK("gp25_rst", 1'b1, gpio_25_27_reset_n)
      lreset_n <= 1'b1;
      wt(8);
      `CHK("grp_rel", 5'h1f, gpio_group_reset_n)
      // Cleared controls: every group and GP25-27 follow the LPC reset
      wr(IDX_GPIO_RST, 8'h00);
      lreset_n <= 1'b0;
      wt(8);
      `CHK("gp25_lrst", 1'b0, gpio_25_27_reset_n)
      `CHK("grp_all", 5'h00, gpio_group_reset_n)
      lreset_n <= 1'b1;
      wt(8);
      // Policy on, shortest delay code: 200 ms of 4 cycles each
      wr(IDX_OPTION, 8'h20);
      wr(IDX_WAKE_PG, 8'h08);
      standby_domain_good <= 1'b1;
      wt(8);
      `CHK("power_on", 1'b1, system_power_on)
      wt(780);
      `CHK("pg_early", 1'b0, power_good)
      wt(30);
      `CHK("pg_late", 1'b1, power_good)
      wr(IDX_WAKE_PG, 8'h29);
      `CHK("case_clr", 1'b1, chassis_intrusion_clear)
      wt(1);
      `CHK("case_end", 1'b0, chassis_intrusion_clear)
      wt(1);
      `CHK("pg_retrig", 1'b0, power_good)
      rd(IDX_WAKE_PG, 32'h08, "self_clr");
      // Every policy code; code 2 recovers the on state held before loss
      for (int p = 0; p < 4; p++)
      begin
         wr(IDX_OPTION, 8'(p << 5));
         cycle_pwr(p != 0);
      end
      wr(IDX_WAKE_PG, 8'h18);
      cycle_pwr(1'b0);
      // Restore-previous with the system off before the loss stays off
      wr(IDX_OPTION, 8'h40);
      cycle_pwr(1'b0);
      test_done();
   end
endmodule : awpc_bench
`default_nettype wire

// [bench/awpc_host_model.sv]
// Host-side pin model: stretches event requests into level pulses
`default_nettype none
module awpc_host_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Event requests and pins
   input wire logic [6:0] ev_req,
   output logic [6:0] ev_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] hold [7]; // Cycles left high
   // Long enough that the agreement filter sees a steady level
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      for (int i = 0; i < 7; i++)
      begin
         if (!rst_n) hold[i] <= 3'h0;
         else if (ev_req[i]) hold[i] <= 3'h6;
         else if (hold[i] != 3'h0) hold[i] <= hold[i] - 3'h1;
      end
   end
   // Pin high while the count runs
   always_comb
   begin
      for (int i = 0; i < 7; i++) ev_pin[i] = (hold[i] != 3'h0);
   end
endmodule : awpc_host_model
`default_nettype wire

// [design/awpc_pg_timer.sv]
// Power-good delay timer driven by a one-millisecond enable
`default_nettype none
module awpc_pg_timer
   import awpc_pkg::*;
#(
   parameter int cycles_per_ms = CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic restart,
   input wire logic [2:0] code,
   // Output
   output logic power_good
);
   logic [MS_DIV_W-1:0] div; // Cycle divider
   logic ms_tick;            // One-cycle pulse each millisecond
   logic [9:0] ms_cnt;       // Elapsed milliseconds
   logic hold;               // Timer held at zero

   assign hold = !run || restart;
   assign ms_tick = (div == MS_DIV_W'(cycles_per_ms - 1));

   // Divider restarts with the timer so the least delay is never shortened
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         div <= '0;
      else if (hold || ms_tick)
         div <= '0;
      else
         div <= div + 1'b1;
   end

   // Millisecond count up to the selected delay
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         ms_cnt <= '0;
      else if (hold)
         ms_cnt <= '0;
      else if (ms_tick && ms_cnt < awpc_delay_ms(code))
         ms_cnt <= ms_cnt + 1'b1;
   end

   // Output low while held, high once the delay has run out
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         power_good <= 1'b0;
      else if (hold)
         power_good <= 1'b0;
      else if (ms_cnt >= awpc_delay_ms(code))
         power_good <= 1'b1;
   end
endmodule : awpc_pg_timer
`default_nettype wire

// [design/awpc_pkg.sv]
// Package: register map, field positions, reset values and timing for wake/power control
`default_nettype none
package awpc_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_STATUS = 8'he3;    // Read-to-clear event flags
   localparam logic [7:0] IDX_OPTION = 8'he4;    // Power-loss policy, keyboard wake
   localparam logic [7:0] IDX_GPIO_RST = 8'he5;  // GPIO reset source select
   localparam logic [7:0] IDX_WAKE_PG = 8'he6;   // Mouse wake, case clear, power good
   localparam logic [7:0] IDX_IRQ_STS = 8'hf0;   // Sticky interrupt status, write 1 clears
   localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;  // Interrupt enable mask
   localparam logic [7:0] IDX_PWR_STATE = 8'hf2; // Power state readback
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ST_THERMAL = 3;
   localparam int ST_PSWITCH = 2;
   localparam int ST_MOUSE = 1;
   localparam int ST_KBD = 0;
   localparam int OPT_POLICY_HI = 6;
   localparam int OPT_POLICY_LO = 5;
   localparam int OPT_KBD_ANY = 3;
   localparam int OPT_HUNT = 2;
   localparam int GPIO_GRP_HI = 7;
   localparam int GPIO_GRP_LO = 3;
   localparam int GPIO_GP25 = 2;
   localparam int WPG_MOUSE_EN = 7;
   localparam int WPG_CASE_CLR = 5;
   localparam int WPG_LAST_OFF = 4;
   localparam int WPG_DLY_HI = 3;
   localparam int WPG_DLY_LO = 1;
   localparam int WPG_RETRIG = 0;
   // ----------------------------------------------------------------
   // Reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0] OPTION_RST = 8'h00;
   localparam logic [7:0] GPIO_RST_RST = 8'h00;
   localparam logic [7:0] WPG_RST = 8'h1c;
   localparam logic [7:0] OPTION_WMASK = 8'h6c;
   localparam logic [7:0] GPIO_WMASK = 8'hfc;
   localparam logic [7:0] WPG_WMASK = 8'h9e;
   // Power-loss policy codes
   localparam logic [1:0] POL_OFF = 2'h0;
   localparam logic [1:0] POL_ON = 2'h1;
   localparam logic [1:0] POL_PREV = 2'h2;
   localparam logic [1:0] POL_USER = 2'h3;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam int MS_DIV_W = 17;
   typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_LOST} awpc_pwr_t;

   // True when an address matches the byte address of a register index
   function automatic logic awpc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a == {2'h0, idx, 2'h0};
   endfunction : awpc_hit

   // Least power-good delay of each code, in ms (low end of each range)
   function automatic logic [9:0] awpc_delay_ms(input logic [2:0] code);
      case (code)
         3'h0: return 10'h12c; // 300 ms
         3'h1: return 10'h14a; // 330 ms
         3'h2: return 10'h186; // 390 ms
         3'h3: return 10'h208; // 520 ms
         3'h4: return 10'h0c8; // 200 ms
         3'h5: return 10'h0e6; // 230 ms
         3'h6: return 10'h122; // 290 ms
         default: return 10'h1a4; // 420 ms
      endcase
   endfunction : awpc_delay_ms
endpackage : awpc_pkg
`default_nettype wire

// [design/awpc_sync3.sv]
// Three-stage input synchroniser with agreement filter
`default_nettype none
module awpc_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Asynchronous inputs and filtered result
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1; // First stage, read only by s2
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // A change is taken only when the second and third stages agree
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         sync_out <= '0;
      end
      else
      begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         sync_out <= (s2 & s3) | (sync_out & (s2 | s3));
      end
   end
endmodule : awpc_sync3
`default_nettype wire

// [design/awpc_top.sv]
// Wake status, power-loss recovery and power-good control behind an APB slave
`default_nettype none
module awpc_top
   import awpc_pkg::*;
#(
   parameter int cycles_per_ms = CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event pins
   input wire logic thermal_shutdown,
   input wire logic power_switch_input,
   input wire logic mouse_left_click,
   input wire logic mouse_right_click,
   input wire logic mouse_activity,
   input wire logic key_any,
   input wire logic key_sequence_match,
   // Supply and reset pins
   input wire logic lreset_n,
   input wire logic resume_well_reset_n,
   input wire logic main_supply_good,
   input wire logic standby_domain_good,
   // Mouse key selects held elsewhere
   input wire logic mouse_right_key_select,
   input wire logic mouse_extra_key_select,
   // Power outputs
   output logic system_power_on,
   output logic power_good,
   output logic chassis_intrusion_clear,
   // GPIO reset outputs
   output logic [4:0] gpio_group_reset_n,
   output logic gpio_25_27_reset_n,
   // Interrupt
   output logic irq
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [10:0] pins_raw; // Raw pin vector
   logic [10:0] pins;     // Filtered pin vector
   logic therm_s, psw_s, mleft_s, mright_s, mact_s, kany_s, kseq_s;
   logic lrst_n_s, rsm_n_s, main_s, stby_s;
   logic [6:0] evl_q;     // Previous event levels for edge detection

   assign pins_raw = {thermal_shutdown, power_switch_input, mouse_left_click,
                      mouse_right_click, mouse_activity, key_any, key_sequence_match,
                      lreset_n, resume_well_reset_n, main_supply_good,
                      standby_domain_good};

   awpc_sync3 #(.W(11)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   assign {therm_s, psw_s, mleft_s, mright_s, mact_s, kany_s, kseq_s,
           lrst_n_s, rsm_n_s, main_s, stby_s} = pins;

   // Edge detection registers for event levels
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         evl_q <= '0;
      else
         evl_q <= pins[10:4];
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] opt_reg;   // Policy and keyboard options
   logic [7:0] gpio_reg;  // GPIO reset sources
   logic [7:0] wpg_reg;   // Mouse enable, last state, delay code
   logic [3:0] status;    // Read-to-clear event flags
   logic [3:0] irq_sts;   // Sticky interrupt status
   logic [3:0] irq_mask;  // Interrupt enables
   logic [3:0] ev;        // Event pulses this cycle
   logic [3:0] rd_cap;    // Status bits captured by the setup of a read
   logic mouse_wake, kbd_wake, wake_any;
   logic [6:0] rise;      // Rising edges of event levels
   logic setup_ph, wr_done, rd_done, mapped;
   logic [31:0] next_prdata;
   awpc_pwr_t pwr_state;
   logic prev_on;         // Recorded on/off state before a loss
   logic retrig;          // One-cycle power-good retrigger
   logic stby_q;          // Delayed standby level

   assign rise = pins[10:4] & ~evl_q;

   // Mouse wake selection from the three key bits
   always_comb
   begin
      if (wpg_reg[WPG_MOUSE_EN] && mouse_extra_key_select)
         mouse_wake = rise[8-4] | rise[7-4] | rise[6-4];
      else if (wpg_reg[WPG_MOUSE_EN])
         mouse_wake = rise[8-4] | rise[7-4];
      else if (mouse_extra_key_select)
         mouse_wake = rise[8-4];
      else
         mouse_wake = mouse_right_key_select & rise[7-4];
   end

   // Keyboard wake: any key or programmed sequence
   assign kbd_wake = opt_reg[OPT_KBD_ANY] ? rise[5-4] : rise[4-4];
   assign ev = {rise[10-4], rise[9-4], mouse_wake, kbd_wake};
   assign wake_any = mouse_wake | kbd_wake;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign mapped = awpc_hit(paddr, IDX_STATUS) || awpc_hit(paddr, IDX_OPTION)
                   || awpc_hit(paddr, IDX_GPIO_RST) || awpc_hit(paddr, IDX_WAKE_PG)
                   || awpc_hit(paddr, IDX_IRQ_STS) || awpc_hit(paddr, IDX_IRQ_MASK)
                   || awpc_hit(paddr, IDX_PWR_STATE);
   // Zero-wait slave: the access phase always completes in one cycle
   assign pready = psel & penable;
   assign pslverr = pready & ~mapped;
   assign setup_ph = psel & ~penable;
   assign wr_done = pready & pwrite & mapped;
   assign rd_done = pready & ~pwrite & awpc_hit(paddr, IDX_STATUS);

   // Read data mux, sampled in the setup phase
   always_comb
   begin
      next_prdata = 32'h0;
      if (awpc_hit(paddr, IDX_STATUS))
         next_prdata[3:0] = status;
      else if (awpc_hit(paddr, IDX_OPTION))
         next_prdata[7:0] = opt_reg;
      else if (awpc_hit(paddr, IDX_GPIO_RST))
         next_prdata[7:0] = gpio_reg;
      else if (awpc_hit(paddr, IDX_WAKE_PG))
         next_prdata[7:0] = wpg_reg;
      else if (awpc_hit(paddr, IDX_IRQ_STS))
         next_prdata[3:0] = irq_sts;
      else if (awpc_hit(paddr, IDX_IRQ_MASK))
         next_prdata[3:0] = irq_mask;
      else if (awpc_hit(paddr, IDX_PWR_STATE))
         next_prdata[3:0] = {prev_on, pwr_state == PWR_LOST, power_good, system_power_on};
   end

   // Read data register; holds through the access phase
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h0;
         rd_cap <= 4'h0;
      end
      else if (setup_ph && !pwrite)
      begin
         prdata <= next_prdata;
         rd_cap <= awpc_hit(paddr, IDX_STATUS) ? status : 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // Event status
   // ----------------------------------------------------------------
   // Only the bits returned are cleared; a new event always wins
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         status <= 4'h0;
      else if (rd_done)
         status <= (status & ~rd_cap) | ev;
      else
         status <= status | ev;
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq_sts <= 4'h0;
      else if (wr_done && awpc_hit(paddr, IDX_IRQ_STS))
         irq_sts <= (irq_sts & ~pwdata[3:0]) | ev;
      else
         irq_sts <= irq_sts | ev;
   end

   // Interrupt mask
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq_mask <= 4'h0;
      else if (wr_done && awpc_hit(paddr, IDX_IRQ_MASK))
         irq_mask <= pwdata[3:0];
   end

   assign irq = |(irq_sts & irq_mask);

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Keyboard bits follow lreset; hunting self-clears on a mouse or keyboard wake
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         opt_reg <= OPTION_RST;
      else
      begin
         if (wr_done && awpc_hit(paddr, IDX_OPTION))
            opt_reg <= pwdata[7:0] & OPTION_WMASK;
         if (!lrst_n_s)
         begin
            opt_reg[OPT_KBD_ANY] <= 1'b0;
            opt_reg[OPT_HUNT] <= 1'b0;
         end
         else if (wake_any)
            opt_reg[OPT_HUNT] <= 1'b0;
      end
   end

   // GPIO reset source register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         gpio_reg <= GPIO_RST_RST;
      else if (wr_done && awpc_hit(paddr, IDX_GPIO_RST))
         gpio_reg <= pwdata[7:0] & GPIO_WMASK;
   end

   // Action bits 5 and 0 are never stored, so they read back as zero
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wpg_reg <= WPG_RST;
      else if (wr_done && awpc_hit(paddr, IDX_WAKE_PG))
         wpg_reg <= pwdata[7:0] & WPG_WMASK;
   end

   // One-cycle action pulses from writes of one
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chassis_intrusion_clear <= 1'b0;
         retrig <= 1'b0;
      end
      else
      begin
         chassis_intrusion_clear <= wr_done && awpc_hit(paddr, IDX_WAKE_PG)
                                    && pwdata[WPG_CASE_CLR];
         retrig <= wr_done && awpc_hit(paddr, IDX_WAKE_PG) && pwdata[WPG_RETRIG];
      end
   end

   // ----------------------------------------------------------------
   // GPIO reset outputs
   // ----------------------------------------------------------------
   // A set control bit keeps lreset away from its group
   assign gpio_group_reset_n = {5{lrst_n_s}} | gpio_reg[GPIO_GRP_HI:GPIO_GRP_LO];
   assign gpio_25_27_reset_n = gpio_reg[GPIO_GP25] ? rsm_n_s : lrst_n_s;

   // ----------------------------------------------------------------
   // Power-loss recovery
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         stby_q <= 1'b0;
      else
         stby_q <= stby_s;
   end

   // Standby loss parks the machine; its return applies the policy
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pwr_state <= PWR_LOST;
      else
      begin
         case (pwr_state)
            PWR_OFF, PWR_ON:
            begin
               if (!stby_s)
                  pwr_state <= PWR_LOST;
               else if (ev[ST_PSWITCH])
                  pwr_state <= (pwr_state == PWR_ON) ? PWR_OFF : PWR_ON;
            end
            PWR_LOST:
            begin
               if (stby_s && !stby_q)
               begin
                  case (opt_reg[OPT_POLICY_HI:OPT_POLICY_LO])
                     POL_OFF: pwr_state <= PWR_OFF;
                     POL_ON: pwr_state <= PWR_ON;
                     POL_PREV: pwr_state <= prev_on ? PWR_ON : PWR_OFF;
                     default: pwr_state <= wpg_reg[WPG_LAST_OFF] ? PWR_OFF : PWR_ON;
                  endcase
               end
            end
            default: pwr_state <= PWR_LOST;
         endcase
      end
   end

   // Running record of on/off, frozen while power is lost
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         prev_on <= 1'b0;
      else if (pwr_state != PWR_LOST)
         prev_on <= (pwr_state == PWR_ON);
   end

   assign system_power_on = (pwr_state == PWR_ON);

   // ----------------------------------------------------------------
   // Power good
   // ----------------------------------------------------------------
   awpc_pg_timer #(.cycles_per_ms(cycles_per_ms)) u_pg (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(system_power_on & main_s),
      .restart(retrig),
      .code(wpg_reg[WPG_DLY_HI:WPG_DLY_LO]),
      .power_good(power_good)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_thermal_flag_set: assert property (ev[ST_THERMAL] |=> status[ST_THERMAL])
      else $error("thermal event did not set status");
   a_pswitch_flag_set: assert property (ev[ST_PSWITCH] |=> status[ST_PSWITCH])
      else $error("power switch event did not set status");
   a_mouse_flag_hold: assert property (status[ST_MOUSE] && !rd_done |=> status[ST_MOUSE])
      else $error("mouse flag dropped without a read");
   a_kbd_read_clear: assert property (rd_done && rd_cap[ST_KBD] && !ev[ST_KBD]
      |=> !status[ST_KBD])
      else $error("keyboard flag not cleared by read");
   a_policy_on_restore: assert property (pwr_state == PWR_LOST && stby_s && !stby_q
      && opt_reg[OPT_POLICY_HI:OPT_POLICY_LO] == POL_ON |=> system_power_on)
      else $error("always-on policy did not power on");
   a_user_state_restore: assert property (pwr_state == PWR_LOST && stby_s && !stby_q
      && opt_reg[OPT_POLICY_HI:OPT_POLICY_LO] == POL_USER && wpg_reg[WPG_LAST_OFF]
      |=> pwr_state == PWR_OFF)
      else $error("user last state off not honoured");
   a_hunt_self_clear: assert property (wake_any |=> !opt_reg[OPT_HUNT])
      else $error("hunting mode not cleared on wake");
   a_gpio_lreset_block: assert property (gpio_reg[GPIO_GRP_HI] |-> gpio_group_reset_n[4])
      else $error("blocked group saw lreset");
   a_case_clear_pulse: assert property (wr_done && awpc_hit(paddr, IDX_WAKE_PG)
      && pwdata[WPG_CASE_CLR] |=> chassis_intrusion_clear ##1 !chassis_intrusion_clear)
      else $error("chassis clear is not a single pulse");
   a_retrigger_low: assert property (retrig |=> !power_good)
      else $error("retrigger did not drop power good");
   a_event_kept_on_read: assert property (rd_done && ev[ST_THERMAL] |=> status[ST_THERMAL])
      else $error("event lost during clearing read");
endmodule : awpc_top
`default_nettype wire
